// ---- design/flexec_consts.vh ----
// Constants for the flag and load execution block
`ifndef FLEXEC_CONSTS_VH
`define FLEXEC_CONSTS_VH

// ----------------------------------------------------------------
// Flag positions in the flag status word
// ----------------------------------------------------------------
`define FLEXEC_FLAG_C 3'h0
`define FLEXEC_FLAG_Z 3'h1
`define FLEXEC_FLAG_N 3'h2
`define FLEXEC_FLAG_V 3'h3
`define FLEXEC_FLAG_S 3'h4
`define FLEXEC_FLAG_H 3'h5
`define FLEXEC_FLAG_T 3'h6
`define FLEXEC_FLAG_I 3'h7
`define FLEXEC_FLAG_STATUS_WORD_RESET 8'h00

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define FLEXEC_OP_NOP 5'h00
`define FLEXEC_OP_COPY 5'h01
`define FLEXEC_OP_PAIR_COPY 5'h02
`define FLEXEC_OP_LD_A 5'h03
`define FLEXEC_OP_LD_A_INC 5'h04
`define FLEXEC_OP_LD_A_DEC 5'h05
`define FLEXEC_OP_LD_B_INC 5'h06
`define FLEXEC_OP_LD_B_DEC 5'h07
`define FLEXEC_OP_LD_C_INC 5'h08
`define FLEXEC_OP_LD_C_DEC 5'h09
`define FLEXEC_OP_LD_B 5'h0A
`define FLEXEC_OP_LD_C 5'h0B
// Raise is 5'b10fff, lower is 5'b11fff, fff the flag position
`define FLEXEC_OP_RAISE_BASE 2'h2
`define FLEXEC_OP_LOWER_BASE 2'h3

// ----------------------------------------------------------------
// Pointer pair locations in the register file (low byte)
// ----------------------------------------------------------------
`define FLEXEC_PTR_A 5'h1A
`define FLEXEC_PTR_B 5'h1C
`define FLEXEC_PTR_C 5'h1E
`define FLEXEC_PTR_STEP 16'h0001

`endif

// ---- design/flexec_core.v ----
// Flag raise/lower, register copy and indirect load execution
//
// Operation
// - carry_raise sets carry, carry_lower clears it, nothing else changes.
// - negative_raise sets negative flag, negative_lower clears it.
// - zero_raise sets zero flag, zero_lower clears it.
// - interrupt_unmask sets global interrupt enable, interrupt_mask clears it.
// - sign_raise sets signed test flag, sign_lower clears it.
// - overflow_raise sets overflow flag, overflow_lower clears it.
// - transfer_bit_raise sets transfer bit, transfer_bit_lower clears it.
// - half_carry_raise sets half carry, half_carry_lower clears it.
// - register_copy writes source_register into destination, source kept.
// - register_pair_copy copies a 16-bit register pair in one write.
// - Plain indirect_load via pointer_pair_a reads memory, pointer unchanged.
// - Post-increment load via pointer_pair_a loads then adds one.
// - Pre-decrement load via pointer_pair_a subtracts one then loads.
// - Post-increment load via pointer_pair_b loads then adds one.
// - Pre-decrement load via pointer_pair_b subtracts one then loads.
// - Post-increment load via pointer_pair_c loads then adds one.
// - Pre-decrement load via pointer_pair_c subtracts one then loads.
`timescale 1ns/1ps
`default_nettype none
`include "flexec_consts.vh"

module flexec_core (
  input wire ref_clk_i,
  input wire rst_n_i,
  input wire instr_valid_i,
  input wire [4:0] instr_op_i,
  input wire [4:0] instr_dst_i,
  input wire [4:0] instr_src_i,
  input wire [4:0] rf_sel_i,
  input wire [7:0] mem_data_i,
  output reg [7:0] flag_status_word_o,
  output reg [7:0] rf_data_o,
  output reg [15:0] mem_addr_o,
  output reg mem_rd_o,
  output reg busy_o,
  output reg done_o
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 1'b0;
  localparam ST_READ = 1'b1;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [7:0] rf_reg [0:31];
  reg [7:0] flag_status_word_reg;
  reg [7:0] flag_status_word_next;
  reg state_reg;
  reg state_next;
  reg [4:0] load_dst_next;
  reg [4:0] load_dst_reg;
  integer i;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [15:0] ptr_value;
    input [4:0] base;
    begin
      ptr_value = {rf_reg[base | 5'h01], rf_reg[base]};
    end
  endfunction

  function [4:0] pair_low;
    input [4:0] idx;
    begin
      pair_low = {idx[4:1], 1'b0};
    end
  endfunction

  function [7:0] flag_mask;
    input [2:0] pos;
    begin
      flag_mask = 8'h01 << pos;
    end
  endfunction

  // ----------------------------------------------------------------
  // Decode of the accepted instruction
  // ----------------------------------------------------------------
  wire accept = instr_valid_i && (state_reg == ST_IDLE);
  wire is_raise = (instr_op_i[4:3] == `FLEXEC_OP_RAISE_BASE);
  wire is_lower = (instr_op_i[4:3] == `FLEXEC_OP_LOWER_BASE);
  wire [2:0] flag_pos = instr_op_i[2:0];
  wire is_copy = (instr_op_i == `FLEXEC_OP_COPY);
  wire is_pair_copy = (instr_op_i == `FLEXEC_OP_PAIR_COPY);

  reg is_load;
  reg [4:0] ptr_base;
  reg ptr_inc;
  reg ptr_dec;

  always @*
  begin
    is_load = 1'b1;
    ptr_base = `FLEXEC_PTR_A;
    ptr_inc = 1'b0;
    ptr_dec = 1'b0;
    case (instr_op_i)
      `FLEXEC_OP_NOP:
      begin
        is_load = 1'b0;
      end
      `FLEXEC_OP_LD_A:
      begin
        ptr_base = `FLEXEC_PTR_A;
      end
      `FLEXEC_OP_LD_A_INC:
      begin
        ptr_base = `FLEXEC_PTR_A;
        ptr_inc = 1'b1;
      end
      `FLEXEC_OP_LD_A_DEC:
      begin
        ptr_base = `FLEXEC_PTR_A;
        ptr_dec = 1'b1;
      end
      `FLEXEC_OP_LD_B:
      begin
        ptr_base = `FLEXEC_PTR_B;
      end
      `FLEXEC_OP_LD_B_INC:
      begin
        ptr_base = `FLEXEC_PTR_B;
        ptr_inc = 1'b1;
      end
      `FLEXEC_OP_LD_B_DEC:
      begin
        ptr_base = `FLEXEC_PTR_B;
        ptr_dec = 1'b1;
      end
      `FLEXEC_OP_LD_C:
      begin
        ptr_base = `FLEXEC_PTR_C;
      end
      `FLEXEC_OP_LD_C_INC:
      begin
        ptr_base = `FLEXEC_PTR_C;
        ptr_inc = 1'b1;
      end
      `FLEXEC_OP_LD_C_DEC:
      begin
        ptr_base = `FLEXEC_PTR_C;
        ptr_dec = 1'b1;
      end
      // Flag ops, copies and unknown codes are not loads
      default: is_load = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Pointer arithmetic, wraps at 16 bits
  // ----------------------------------------------------------------
  wire [15:0] ptr_old = ptr_value(ptr_base);
  wire [15:0] ptr_plus = ptr_old + `FLEXEC_PTR_STEP;
  wire [15:0] ptr_minus = ptr_old - `FLEXEC_PTR_STEP;
  // Pre-decrement reads the new address, other forms the old one
  wire [15:0] load_addr = ptr_dec ? ptr_minus : ptr_old;
  wire [15:0] ptr_new = ptr_inc ? ptr_plus : ptr_minus;
  wire ptr_step = ptr_inc || ptr_dec;

  // ----------------------------------------------------------------
  // Flag word update
  // ----------------------------------------------------------------
  always @*
  begin
    flag_status_word_next = flag_status_word_reg;
    if (accept && is_raise)
    begin
      flag_status_word_next = flag_status_word_reg | flag_mask(flag_pos);
    end
    else if (accept && is_lower)
    begin
      flag_status_word_next = flag_status_word_reg & ~flag_mask(flag_pos);
    end
  end

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always @*
  begin
    state_next = state_reg;
    load_dst_next = load_dst_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (accept && is_load)
        begin
          state_next = ST_READ;
          load_dst_next = instr_dst_i;
        end
      end
      ST_READ:
      begin
        // Data returns in this cycle, so idle again after it
        state_next = ST_IDLE;
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer and flag word registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      load_dst_reg <= 5'h00;
      flag_status_word_reg <= `FLEXEC_FLAG_STATUS_WORD_RESET;
    end
    else
    begin
      state_reg <= state_next;
      load_dst_reg <= load_dst_next;
      flag_status_word_reg <= flag_status_word_next;
    end
  end

  // ----------------------------------------------------------------
  // Register file writes
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (i = 0; i < 32; i = i + 1)
      begin
        rf_reg[i] <= 8'h00;
      end
    end
    else if (state_reg == ST_READ)
    begin
      // Loaded byte lands one edge after the pointer update, so it wins
      rf_reg[load_dst_reg] <= mem_data_i;
    end
    else if (accept)
    begin
      if (is_load && ptr_step)
      begin
        // Pointer pair steps at the taking edge
        rf_reg[ptr_base] <= ptr_new[7:0];
        rf_reg[ptr_base | 5'h01] <= ptr_new[15:8];
      end
      else if (is_copy)
      begin
        rf_reg[instr_dst_i] <= rf_reg[instr_src_i];
      end
      else if (is_pair_copy)
      begin
        rf_reg[pair_low(instr_dst_i)] <= rf_reg[pair_low(instr_src_i)];
        rf_reg[pair_low(instr_dst_i) | 5'h01] <=
          rf_reg[pair_low(instr_src_i) | 5'h01];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file peek, one cycle behind the select
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rf_data_o <= 8'h00;
    end
    else
    begin
      rf_data_o <= rf_reg[rf_sel_i];
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flag_status_word_o <= `FLEXEC_FLAG_STATUS_WORD_RESET;
      mem_addr_o <= 16'h0000;
      mem_rd_o <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      flag_status_word_o <= flag_status_word_next;
      // Strobe and busy mark the single data return cycle of a load
      mem_rd_o <= (state_next == ST_READ);
      busy_o <= (state_next == ST_READ);
      // Loads finish the cycle after the return cycle, everything else at once
      done_o <= (state_reg == ST_READ) || (accept && !is_load);
      if (accept && is_load)
      begin
        // Address goes out now, data returns in the next cycle
        mem_addr_o <= load_addr;
      end
    end
  end

endmodule // flexec_core
`default_nettype wire

// ---- bench/flexec_core_asserts.sv ----
// Concurrent checks on the flag and load execution block ports
`timescale 1ns/1ps
`default_nettype none
module flexec_core_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [4:0] instr_op_i,
  input wire logic [7:0] flag_status_word_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_rd_o,
  input wire logic busy_o,
  input wire logic done_o
);
  wire take = instr_valid_i && !busy_o;
  wire ld = take && instr_op_i >= 5'h03 && instr_op_i <= 5'h0B;
  wire [7:0] bit_of = 8'h01 << instr_op_i[2:0];
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_raise_flag: assert property (
    take && instr_op_i[4:3] == 2'h2 |=> flag_status_word_o == ($past(flag_status_word_o)
    | $past(bit_of))) else $error("raise did not set exactly its flag");
  a_lower_flag: assert property (
    take && instr_op_i[4:3] == 2'h3 |=> flag_status_word_o == ($past(flag_status_word_o)
    & ~$past(bit_of))) else $error("lower did not clear exactly its flag");
  a_flags_kept: assert property (!(take && instr_op_i[4]) |=>
    $stable(flag_status_word_o)) else $error("flags moved without a flag op");
  a_load_walk: assert property (ld |=> mem_rd_o && busy_o ##1
    !mem_rd_o && !busy_o && done_o) else $error("load did not take two cycles");
  a_quick_done: assert property (take && !ld |=> done_o && !mem_rd_o)
    else $error("non-load did not finish in one cycle");
  a_addr_holds: assert property (!$rose(mem_rd_o) |-> $stable(mem_addr_o))
    else $error("load address moved outside a read");
  a_rd_single: assert property (mem_rd_o |=> !mem_rd_o)
    else $error("read strobe longer than one cycle");
  a_done_cause: assert property (done_o |-> $past(take) || $past(busy_o))
    else $error("done without an instruction");
  c_raise: cover property (take && instr_op_i[4:3] == 2'h2);
  c_load: cover property (ld ##1 mem_rd_o);
  c_copy: cover property (take && instr_op_i == 5'h02);
endmodule // flexec_core_asserts
bind flexec_core flexec_core_asserts i_flexec_core_asserts (.ref_clk_i(ref_clk_i),
  .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
  .flag_status_word_o(flag_status_word_o), .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o), .busy_o(busy_o), .done_o(done_o));
`default_nettype wire

// ---- bench/flexec_core_tb.sv ----
// Self-checking bench for the flag and load execution block
`timescale 1ns/1ps
`default_nettype none
module flexec_core_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [4:0] instr_op_i = 5'h00;
  logic [4:0] instr_dst_i = 5'h00;
  logic [4:0] instr_src_i = 5'h00;
  logic [4:0] rf_sel_i = 5'h00;
  wire [7:0] mem_data_i;
  wire [7:0] flag_status_word_o;
  wire [7:0] rf_data_o;
  wire [15:0] mem_addr_o;
  wire mem_rd_o;
  wire busy_o;
  wire done_o;
  int err_total = 0;
  int tests_run = 0;
  logic [7:0] fexp;
  always #50 ref_clk_i = ~ref_clk_i;
  // Memory byte is the sum of the address halves plus 8'h3C, so addresses with equal half sums read the same
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] + a[15:8] + 8'h3C;
  endfunction
  assign mem_data_i = mb(mem_addr_o);
  flexec_core i_flexec_core (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i), .instr_dst_i(instr_dst_i),
    .instr_src_i(instr_src_i), .rf_sel_i(rf_sel_i), .mem_data_i(mem_data_i),
    .flag_status_word_o(flag_status_word_o), .rf_data_o(rf_data_o),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .busy_o(busy_o), .done_o(done_o));
  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic run(input logic [4:0] op, input logic [4:0] d, input logic [4:0] s);
    int n;
    @(negedge ref_clk_i);
    instr_valid_i = 1'b1;
    instr_op_i = op;
    instr_dst_i = d;
    instr_src_i = s;
    @(negedge ref_clk_i);
    instr_valid_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 4)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    if (n == 4)
    begin
      err_total++;
      close_out();
    end
  endtask
  task automatic reg_is(input logic [4:0] sel, input logic [7:0] e);
    @(negedge ref_clk_i);
    rf_sel_i = sel;
    @(negedge ref_clk_i);
    chk("reg", e, rf_data_o);
  endtask
  task automatic ld(input logic [4:0] op, input logic [4:0] d, input logic [15:0] a);
    run(op, d, 5'h00);
    chk("addr", a, mem_addr_o);
    reg_is(d, mb(a));
  endtask
  initial
  begin
    repeat (3) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    fexp = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      run({i[3] ? 2'h3 : 2'h2, i[2:0]}, 5'h00, 5'h00);
      fexp[i[2:0]] = !i[3];
      chk("flags low", fexp[3:0], flag_status_word_o[3:0]);
      chk("flags high", fexp[7:4], flag_status_word_o[7:4]);
    end
    $display("test flags done");
    run(5'h10, 5'h00, 5'h00);
    run(5'h17, 5'h00, 5'h00);
    run(5'h00, 5'h00, 5'h00);
    run(5'h0F, 5'h00, 5'h00);
    ld(5'h03, 5'h1A, 16'h0000);
    ld(5'h04, 5'h05, 16'h003C);
    ld(5'h05, 5'h06, 16'h003C);
    ld(5'h03, 5'h07, 16'h003C);
    ld(5'h07, 5'h08, 16'hFFFF);
    ld(5'h06, 5'h09, 16'hFFFF);
    ld(5'h0A, 5'h0A, 16'h0000);
    ld(5'h08, 5'h0B, 16'h0000);
    ld(5'h0B, 5'h0D, 16'h0001);
    ld(5'h09, 5'h0C, 16'h0000);
    $display("test loads done");
    run(5'h01, 5'h10, 5'h06);
    reg_is(5'h10, 8'h78);
    reg_is(5'h06, 8'h78);
    run(5'h02, 5'h14, 5'h0C);
    reg_is(5'h14, 8'h3C);
    reg_is(5'h15, 8'h3D);
    chk("flags", 8'h81, flag_status_word_o);
    $display("test copies done");
    close_out();
  end
endmodule // flexec_core_tb
`default_nettype wire
